// file: src/cmpf_pkg.sv
package cmpf_pkg;
  // mode selector codes
  localparam logic [1:0] CMPF_MODE_MEM = 2'h0;
  localparam logic [1:0] CMPF_MODE_IO = 2'h1;
  localparam logic [1:0] CMPF_MODE_DISK = 2'h2;
  // address bus layout
  localparam int CMPF_ADDR_W = 11;
  localparam int CMPF_TF_W = 3;
  localparam logic [10:0] CMPF_ADDR_ZERO = 11'h000;
  // settle time before card-detect is trusted
  localparam int CMPF_DEBOUNCE_NS = 1000;
  localparam int CMPF_CLK_NS = 5;
  localparam int CMPF_DEBOUNCE_CYC = (CMPF_DEBOUNCE_NS + CMPF_CLK_NS - 1) / CMPF_CLK_NS;
  localparam int CMPF_CNT_W = 8;
endpackage : cmpf_pkg

// file: src/cmpf_host.sv
// Notes on behaviour
// - disk mode: host grounds all address lines above the lowest three.
// - disk mode: pass-diagnostic is shared handshake; slave drives, master samples.
// - disk mode: drive-active/slave-present is shared handshake line.
// - host treats card inserted only when both detect lines read low.
`timescale 1ns/10ps
`default_nettype none
module cmpf_host
  import cmpf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // user side
  input wire logic [1:0] mode_i,
  input wire logic [10:0] user_addr_i,
  input wire logic user_reg_sel_i,
  input wire logic host_as_slave_i,
  input wire logic host_diag_pass_i,
  input wire logic host_active_i,
  output logic card_present_o,
  output logic status_alert_o,
  output logic battery_ok_o,
  output logic audio_o,
  output logic peer_diag_pass_o,
  output logic peer_active_o,
  // card pins
  output logic [10:0] addr_o,
  output logic attr_sel_n_o,
  output logic master_slave_select_o,
  output logic master_slave_select_oe_o,
  input wire logic card_detect_first_i,
  input wire logic card_detect_second_i,
  input wire logic battery_detect_first_i,
  input wire logic battery_detect_second_i,
  input wire logic pass_diagnostic_line_i,
  output logic pass_diagnostic_line_o,
  output logic pass_diagnostic_line_oe_o,
  input wire logic drive_active_slave_present_i,
  output logic drive_active_slave_present_o,
  output logic drive_active_slave_present_oe_o
);
  // pin synchronisers, two stages each; only stage two feeds logic
  logic [5:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic cd1_s, cd2_s, battery_detect_first_s, battery_detect_second_s, pass_diagnostic_line_s, drive_active_slave_present_s;
  // insertion debounce
  logic [CMPF_CNT_W-1:0] deb_q, deb_d;
  logic present_q, present_d;
  // address and attribute select toward the card
  logic [CMPF_ADDR_W-1:0] addr_q, addr_d;
  logic attr_q, attr_d;
  // open-drain enables for select and shared handshake lines
  logic msel_oe_q, msel_oe_d;
  logic pass_diagnostic_line_oe_q, pass_diagnostic_line_oe_d;
  logic drive_active_slave_present_oe_q, drive_active_slave_present_oe_d;
  // sensed pin status toward the user
  logic alert_q, alert_d, batt_q, batt_d, audio_q, audio_d;
  logic pd_q, pd_d, act_q, act_d;

  // low-active pin sense shared by several paths
  function automatic logic cmpf_low(input logic pin);
    return ~pin;
  endfunction : cmpf_low

  // mode test used by the address, handshake and status groups
  function automatic logic cmpf_is(input logic [1:0] cur, input logic [1:0] want);
    return cur == want;
  endfunction : cmpf_is

  // synchronised pin views
  assign {drive_active_slave_present_s, pass_diagnostic_line_s, battery_detect_second_s, battery_detect_first_s, cd2_s, cd1_s} = sync2_q;

  // synchroniser next values
  always_comb begin
    sync1_d = {drive_active_slave_present_i, pass_diagnostic_line_i, battery_detect_second_i,
               battery_detect_first_i, card_detect_second_i, card_detect_first_i};
    sync2_d = sync1_q;
  end

  // synchroniser stages; reset to idle high so no false event follows reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1_q <= 6'h3F;
      sync2_q <= 6'h3F;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // debounce next values; a seating card bounces, so presence waits
  always_comb begin
    if (cmpf_low(cd1_s) && cmpf_low(cd2_s)) begin
      deb_d = (deb_q == CMPF_CNT_W'(CMPF_DEBOUNCE_CYC)) ? deb_q : deb_q + 1'b1;
    end else begin
      deb_d = '0;
    end
    present_d = (deb_q == CMPF_CNT_W'(CMPF_DEBOUNCE_CYC));
  end

  // debounce registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      deb_q <= '0;
      present_q <= 1'b0;
    end else begin
      deb_q <= deb_d;
      present_q <= present_d;
    end
  end

  // address next values
  always_comb begin
    addr_d = user_addr_i;
    attr_d = ~user_reg_sel_i;
    if (cmpf_is(mode_i, CMPF_MODE_DISK)) begin
      addr_d = CMPF_ADDR_ZERO | CMPF_ADDR_W'(user_addr_i[CMPF_TF_W-1:0]);
      attr_d = 1'b1;
    end
  end

  // address registers; lines idle at zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_q <= CMPF_ADDR_ZERO;
      attr_q <= 1'b1;
    end else begin
      addr_q <= addr_d;
      attr_q <= attr_d;
    end
  end

  // handshake next values
  always_comb begin
    msel_oe_d = !cmpf_is(mode_i, CMPF_MODE_DISK) || !host_as_slave_i;
    pass_diagnostic_line_oe_d = cmpf_is(mode_i, CMPF_MODE_DISK) && host_as_slave_i && host_diag_pass_i;
    drive_active_slave_present_oe_d = cmpf_is(mode_i, CMPF_MODE_DISK) && host_active_i;
  end

  // handshake registers; select grounded from reset, released only in disk mode with host as slave
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      msel_oe_q <= 1'b1;
      pass_diagnostic_line_oe_q <= 1'b0;
      drive_active_slave_present_oe_q <= 1'b0;
    end else begin
      msel_oe_q <= msel_oe_d;
      pass_diagnostic_line_oe_q <= pass_diagnostic_line_oe_d;
      drive_active_slave_present_oe_q <= drive_active_slave_present_oe_d;
    end
  end

  // status next values; pins are shared, so the mode picks the meaning
  always_comb begin
    alert_d = present_q && cmpf_is(mode_i, CMPF_MODE_IO) && cmpf_low(battery_detect_first_s);
    batt_d = present_q && cmpf_is(mode_i, CMPF_MODE_MEM) && battery_detect_first_s && battery_detect_second_s;
    audio_d = present_q && cmpf_is(mode_i, CMPF_MODE_IO) && cmpf_low(battery_detect_second_s);
    pd_d = cmpf_is(mode_i, CMPF_MODE_DISK) && cmpf_low(pass_diagnostic_line_s);
    act_d = cmpf_is(mode_i, CMPF_MODE_DISK) && cmpf_low(drive_active_slave_present_s);
  end

  // status registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alert_q <= 1'b0;
      batt_q <= 1'b0;
      audio_q <= 1'b0;
      pd_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      alert_q <= alert_d;
      batt_q <= batt_d;
      audio_q <= audio_d;
      pd_q <= pd_d;
      act_q <= act_d;
    end
  end

  // outputs; open-drain data is constant low
  assign card_present_o = present_q;
  assign status_alert_o = alert_q;
  assign battery_ok_o = batt_q;
  assign audio_o = audio_q;
  assign peer_diag_pass_o = pd_q;
  assign peer_active_o = act_q;
  assign addr_o = addr_q;
  assign attr_sel_n_o = attr_q;
  assign master_slave_select_o = 1'b0;
  assign master_slave_select_oe_o = msel_oe_q;
  assign pass_diagnostic_line_o = 1'b0;
  assign pass_diagnostic_line_oe_o = pass_diagnostic_line_oe_q;
  assign drive_active_slave_present_o = 1'b0;
  assign drive_active_slave_present_oe_o = drive_active_slave_present_oe_q;
endmodule : cmpf_host
`default_nettype wire

// file: tb/cmpf_host_properties.sv
`timescale 1ns/10ps
`default_nettype none
module cmpf_host_properties import cmpf_pkg::*; (
  input wire logic ref_clk_i, rst_i, host_as_slave_i, host_active_i, card_detect_first_i,
  input wire logic [1:0] mode_i,
  input wire logic [10:0] user_addr_i, addr_o,
  input wire logic card_present_o, master_slave_select_oe_o, pass_diagnostic_line_o,
  input wire logic pass_diagnostic_line_oe_o, drive_active_slave_present_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic dsk = mode_i == CMPF_MODE_DISK;
  sequence s_detect_lost;
    card_detect_first_i;
  endsequence
  sequence s_present_gone;
    ##4 !card_present_o;
  endsequence
  chk_addr_upper: assert property (dsk |=> addr_o[10:3] == 8'h00) else $error("upper address driven");
  chk_addr_low: assert property (1 |=> addr_o[2:0] == $past(user_addr_i[2:0])) else $error("low address lost");
  chk_addr_full: assert property (!dsk |=> addr_o == $past(user_addr_i)) else $error("address wrong");
  chk_present_drop: assert property (s_detect_lost |-> s_present_gone) else $error("present kept");
  chk_msel_slave: assert property (dsk && host_as_slave_i |=> !master_slave_select_oe_o) else $error("select held");
  chk_msel_ground: assert property (!dsk |=> master_slave_select_oe_o) else $error("select open");
  chk_diag_low: assert property (!(dsk && host_as_slave_i) |=> !pass_diagnostic_line_oe_o) else $error("diag pulled");
  chk_active_drive: assert property (dsk && host_active_i |=> drive_active_slave_present_oe_o) else $error("idle");
endmodule : cmpf_host_properties
`default_nettype wire

// file: tb/cmpf_card.sv
`timescale 1ns/10ps
`default_nettype none
module cmpf_card (
  input wire logic ins_i, ev_i, msel_i,
  output logic cd1_o, cd2_o, bv1_o, bv2_o, pd_oe_o
);
  assign cd1_o = !ins_i;
  assign cd2_o = !ins_i;
  assign bv1_o = !ev_i;
  assign bv2_o = !ev_i;
  assign pd_oe_o = ins_i & msel_i;
endmodule : cmpf_card
`default_nettype wire

// file: tb/test_card_mode_pin_functions.sv
`timescale 1ns/10ps
`default_nettype none
module test_card_mode_pin_functions;
  import cmpf_pkg::*;
  logic ref_clk_i = 1'h0, rst_i = 1'h1, user_reg_sel_i = 1'h1, host_as_slave_i = 1'h0, host_diag_pass_i = 1'h0;
  logic host_active_i = 1'h0, ins = 1'h0, ev = 1'h0, coe;
  logic [1:0] mode_i = 2'h0;
  logic [10:0] user_addr_i = 11'h7FF, addr_o;
  logic card_present_o, status_alert_o, battery_ok_o, audio_o, peer_diag_pass_o, peer_active_o, attr_sel_n_o;
  logic master_slave_select_o, master_slave_select_oe_o, pass_diagnostic_line_o, pass_diagnostic_line_oe_o;
  logic drive_active_slave_present_o, drive_active_slave_present_oe_o;
  logic card_detect_first_i, card_detect_second_i, battery_detect_first_i, battery_detect_second_i;
  // open-drain lines: low when either party pulls
  wire logic pass_diagnostic_line_i = !(pass_diagnostic_line_oe_o | coe);
  wire logic drive_active_slave_present_i = !(drive_active_slave_present_oe_o | coe);
  int mismatches = 0, checks = 0;
  cmpf_host i_dut (.*);
  cmpf_card u_card (.ins_i(ins), .ev_i(ev), .msel_i(!master_slave_select_oe_o), .cd1_o(card_detect_first_i),
    .cd2_o(card_detect_second_i), .bv1_o(battery_detect_first_i), .bv2_o(battery_detect_second_i), .pd_oe_o(coe));
  initial forever #2.5 ref_clk_i = !ref_clk_i;
  task cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  task chk(input logic [10:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // every mode with all address lines high
  task t_addr;
    for (int m = 0; m < 3; m++) begin
      mode_i = m[1:0];
      cyc(2);
      chk(addr_o, m == 2 ? 11'h007 : 11'h7FF);
      chk(attr_sel_n_o, m == 2);
    end
  endtask : t_addr
  // insertion debounce, then io events
  task t_present;
    int n;
    mode_i = CMPF_MODE_MEM;
    ins = 1'h1;
    for (n = 0; n < 300 && !card_present_o; n++) cyc(1);
    if (n == 300) begin
      mismatches++;
      wrap_up;
    end
    chk(n > 199 && n < 206, 1'h1);
    cyc(2);
    chk(battery_ok_o, 1'h1);
    mode_i = CMPF_MODE_IO;
    ev = 1'h1;
    cyc(5);
    chk(status_alert_o, 1'h1);
    chk(audio_o, 1'h1);
    ev = 1'h0;
    cyc(5);
    chk(audio_o, 1'h0);
  endtask : t_present
  // master drive, then slave answer, then removal
  task t_disk;
    mode_i = CMPF_MODE_DISK;
    host_active_i = 1'h1;
    cyc(5);
    chk(peer_active_o, 1'h1);
    host_active_i = 1'h0;
    host_as_slave_i = 1'h1;
    host_diag_pass_i = 1'h1;
    cyc(5);
    chk(master_slave_select_oe_o, 1'h0);
    chk(peer_diag_pass_o, 1'h1);
    ins = 1'h0;
    cyc(5);
    chk(card_present_o, 1'h0);
  endtask : t_disk
  initial begin
    cyc(4);
    rst_i = 1'h0;
    t_addr;
    t_present;
    t_disk;
    wrap_up;
  end
endmodule : test_card_mode_pin_functions
bind cmpf_host cmpf_host_properties u_chk (.*);
`default_nettype wire
